// *** hdl/fcr_pkg.sv ***
// constants and types shared by the flash command address register bank
package fcr_pkg;
    // register byte addresses on the peripheral bus
    localparam logic [31:0] FCR_OFS_RAM_CTRL   = 32'h007fe054;
    localparam logic [31:0] FCR_OFS_STATUS     = 32'h007fe080;
    localparam logic [31:0] FCR_OFS_START_ADDR = 32'h007fe030;
    localparam logic [31:0] FCR_OFS_END_ADDR   = 32'h007fe034;
    localparam logic [31:0] FCR_OFS_INIT       = 32'h007fe08c;
    localparam logic [31:0] FCR_OFS_BC_CTRL    = 32'h007fe0d0;
    // reset values
    localparam logic [31:0] FCR_RST_ADDR       = 32'h00000000;
    localparam logic [1:0]  FCR_RST_RAM_CTRL   = 2'h0;
    // field positions
    localparam int          FCR_BIT_RAM_EN     = 0;
    localparam int          FCR_BIT_RAM_MODE   = 1;
    localparam int          FCR_BIT_READY      = 15;
    localparam int          FCR_BIT_INIT       = 0;
    localparam int          FCR_BIT_BC_DIR     = 0;
    localparam int          FCR_CF_HIGH_LSB    = 24;
    localparam int          FCR_DF_HIGH_LSB    = 19;
    localparam int          FCR_ADDR_LOW_RO    = 2;
    localparam logic [7:0]  FCR_RAM_KEY        = 8'hc4;
    // start address boundaries as a count of ignored low bits
    localparam int          FCR_BND_CF_PROG    = 8;
    localparam int          FCR_BND_DF_PROG    = 2;
    localparam int          FCR_BND_BLOCK_8K   = 13;
    localparam int          FCR_BND_BLOCK_32K  = 15;
    localparam int          FCR_BND_DF_ERASE   = 6;
    localparam int          FCR_BND_CONFIG     = 4;

    typedef enum logic [2:0] {
        FCR_CMD_CF_PROG,
        FCR_CMD_DF_PROG,
        FCR_CMD_CF_ERASE,
        FCR_CMD_DF_ERASE,
        FCR_CMD_BLANK,
        FCR_CMD_CONFIG,
        FCR_CMD_LOCK_PROG,
        FCR_CMD_LOCK_READ
    } fcr_cmd_t;
endpackage

// *** hdl/fcr_ram_gate.sv ***
// firmware ram access gate driven by the enable and transfer mode bits
`timescale 1ns/1ps
module fcr_ram_gate
    import fcr_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic ce_in,
    input  wire logic ram_en_in,
    input  wire logic ram_mode_in,
    input  wire logic rd_req_in,
    input  wire logic wr_req_in,
    input  wire logic hs_req_in,
    output logic      rd_ok_out,
    output logic      wr_ok_out,
    output logic      deny_out
);
    logic next_rd_ok;
    logic next_wr_ok;
    logic next_deny;

    always_comb
    begin
        next_rd_ok = 1'b0;
        next_wr_ok = 1'b0;
        if (ram_en_in) // R14
        begin
            if (!ram_mode_in) // R15
            begin
                next_rd_ok = rd_req_in;
                next_wr_ok = wr_req_in;
            end
            else
            begin
                next_wr_ok = wr_req_in && hs_req_in; // R15
            end
        end
        next_deny = (rd_req_in || wr_req_in) && !(next_rd_ok || next_wr_ok);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            rd_ok_out <= 1'b0;
            wr_ok_out <= 1'b0;
            deny_out  <= 1'b0;
        end
        else if (ce_in)
        begin
            rd_ok_out <= next_rd_ok;
            wr_ok_out <= next_wr_ok;
            deny_out  <= next_deny;
        end
    end
endmodule // fcr_ram_gate

// *** hdl/fcr_regs.sv ***
// flash command address registers, ram access control and blank check order check
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// Contract
// (R01) address registers take writes only while the ready flag is 1
// (R02) the two lowest bits of both address registers are read-only
// (R03) start address bits below the command's boundary are ignored
// (R04) code area commands ignore start address bits 31 to 24
// (R05) data area commands ignore start address bits 31 to 19
// (R06) start address clears on reset and on init bit written 1
// (R07) end address clears on reset and on init bit written 1
// (R08) blank check ignores end address bits 31 to 19 and 1 to 0
// (R09) incrementing blank check needs start below end
// (R10) decrementing blank check needs start above end
// (R11) blank check with inconsistent order locks the sequencer
// (R12) ram enable and mode change only on 16-bit write with key c4; the code takes any write with byte strobes 1 and 0 set, 32-bit ones too
// (R13) key byte stores nothing and reads zero
// (R14) ram enable 0 blocks firmware ram access, 1 allows it
// (R15) mode 0 allows reads and writes, mode 1 only high-speed writes
// (R16) software stops the sequencer before writing firmware ram
// (R17) ram control bits 7 to 2 read zero
// (R18) ready flag is 1 only while no command is in progress
// (R19) key check needs both low byte strobes in one access
module fcr_regs
    import fcr_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic [31:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        seq_busy_in,
    input  wire logic        cmd_issue_in,
    input  wire fcr_cmd_t    cmd_kind_in,
    input  wire logic        cmd_big_block_in,
    input  wire logic        lock_clear_in,
    output logic             cmd_go_out,
    output logic [31:0]      eff_start_out,
    output logic [31:0]      eff_end_out,
    output logic             cmd_lock_out,
    output logic             ram_en_out,
    output logic             ram_mode_out,
    input  wire logic        fw_rd_in,
    input  wire logic        fw_wr_in,
    input  wire logic        fw_hs_in,
    output logic             fw_rd_ok_out,
    output logic             fw_wr_ok_out,
    output logic             fw_deny_out
);
    logic [31:0] start_addr;
    logic [31:0] end_addr;
    logic        ready;
    logic        bc_dir;
    logic        wait_q;
    logic [31:0] next_start_addr;
    logic [31:0] next_end_addr;
    logic        next_ready;
    logic        next_bc_dir;
    logic        next_wait;
    logic [31:0] next_readdata;
    logic        next_ram_en;
    logic        next_ram_mode;
    logic        next_go;
    logic [31:0] next_eff_start;
    logic [31:0] next_eff_end;
    logic        next_lock;
    logic        req;
    logic        acc_wr;
    logic        hit_start;
    logic        hit_end;
    logic        hit_ctrl;
    logic        hit_init;
    logic        hit_bc;
    logic        hit_status;
    logic        key_ok;
    logic        do_init;
    logic        bc_bad;
    logic [31:0] wmask;

    // mask that keeps the address bits at and above a given boundary width, clearing the low-order bits
    function automatic logic [31:0] keep_above(input int nbits);
        keep_above = 32'hffffffff << nbits;
    endfunction

    assign req        = avs_read_in || avs_write_in;
    assign acc_wr     = avs_write_in && !wait_q;
    assign hit_start  = avs_address_in == FCR_OFS_START_ADDR;
    assign hit_end    = avs_address_in == FCR_OFS_END_ADDR;
    assign hit_ctrl   = avs_address_in == FCR_OFS_RAM_CTRL;
    assign hit_init   = avs_address_in == FCR_OFS_INIT;
    assign hit_bc     = avs_address_in == FCR_OFS_BC_CTRL;
    assign hit_status = avs_address_in == FCR_OFS_STATUS;
    assign key_ok     = (avs_byteenable_in[1:0] == 2'h3) && (avs_writedata_in[15:8] == FCR_RAM_KEY); // R12 R19
    assign do_init    = acc_wr && hit_init && avs_byteenable_in[0] && avs_writedata_in[FCR_BIT_INIT];
    assign wmask      = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    // bus slave: waitrequest drops for one cycle, the access takes effect at that edge
    always_comb
    begin
        next_wait     = !(req && wait_q);
        next_readdata = avs_readdata_out;
        if (avs_read_in && wait_q)
        begin
            next_readdata = 32'h00000000;
            if (hit_start)
                next_readdata = start_addr;
            else if (hit_end)
                next_readdata = end_addr;
            else if (hit_ctrl)
                next_readdata = {30'h00000000, ram_mode_out, ram_en_out}; // R13 R17
            else if (hit_status)
                next_readdata = {16'h0000, ready, 15'h0000};
            else if (hit_bc)
                next_readdata = {31'h00000000, bc_dir};
        end
    end

    // address registers, blank check direction and ready flag
    always_comb
    begin
        next_start_addr = start_addr;
        next_end_addr   = end_addr;
        next_bc_dir     = bc_dir;
        next_ready      = !seq_busy_in; // R18
        if (acc_wr && hit_start && ready) // R01
            next_start_addr = ((avs_writedata_in & wmask) | (start_addr & ~wmask)) & keep_above(FCR_ADDR_LOW_RO); // R02
        if (acc_wr && hit_end && ready) // R01
            next_end_addr = ((avs_writedata_in & wmask) | (end_addr & ~wmask)) & keep_above(FCR_ADDR_LOW_RO); // R02
        if (acc_wr && hit_bc && avs_byteenable_in[0])
            next_bc_dir = avs_writedata_in[FCR_BIT_BC_DIR];
        if (do_init)
        begin
            next_start_addr = FCR_RST_ADDR; // R06
            next_end_addr   = FCR_RST_ADDR; // R07
        end
    end

    // key protected firmware ram control
    always_comb
    begin
        next_ram_en   = ram_en_out;
        next_ram_mode = ram_mode_out;
        if (acc_wr && hit_ctrl && key_ok) // R12 R19
        begin
            next_ram_en   = avs_writedata_in[FCR_BIT_RAM_EN];
            next_ram_mode = avs_writedata_in[FCR_BIT_RAM_MODE];
        end
    end

    // command address masking and blank check order check
    always_comb
    begin
        next_go        = 1'b0;
        next_eff_start = eff_start_out;
        next_eff_end   = eff_end_out;
        next_lock      = cmd_lock_out && !lock_clear_in;
        bc_bad         = 1'b0;
        if (cmd_issue_in)
        begin
            next_eff_end = end_addr & keep_above(FCR_ADDR_LOW_RO)
                         & ~keep_above(FCR_DF_HIGH_LSB); // R08
            unique case (cmd_kind_in)
                FCR_CMD_CF_PROG:
                    next_eff_start = start_addr & keep_above(FCR_BND_CF_PROG); // R03
                FCR_CMD_DF_PROG, FCR_CMD_BLANK:
                    next_eff_start = start_addr & keep_above(FCR_BND_DF_PROG); // R03
                FCR_CMD_CF_ERASE, FCR_CMD_LOCK_PROG, FCR_CMD_LOCK_READ:
                    next_eff_start = start_addr & keep_above(cmd_big_block_in ? FCR_BND_BLOCK_32K
                                                                             : FCR_BND_BLOCK_8K); // R03
                FCR_CMD_DF_ERASE:
                    next_eff_start = start_addr & keep_above(FCR_BND_DF_ERASE); // R03
                FCR_CMD_CONFIG:
                    next_eff_start = start_addr & keep_above(FCR_BND_CONFIG); // R03
            endcase
            if (cmd_kind_in inside {FCR_CMD_CF_PROG, FCR_CMD_CF_ERASE, FCR_CMD_LOCK_PROG, FCR_CMD_LOCK_READ})
                next_eff_start = next_eff_start & ~keep_above(FCR_CF_HIGH_LSB); // R04
            else
                next_eff_start = next_eff_start & ~keep_above(FCR_DF_HIGH_LSB); // R05
            if (cmd_kind_in == FCR_CMD_BLANK)
                bc_bad = bc_dir ? !(next_eff_start > next_eff_end)   // R10
                                : !(next_eff_start < next_eff_end);  // R09
            if (bc_bad)
                next_lock = 1'b1; // R11
            else
                next_go = 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            start_addr          <= FCR_RST_ADDR; // R06
            end_addr            <= FCR_RST_ADDR; // R07
            ready               <= 1'b1;
            bc_dir              <= 1'b0;
            wait_q              <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
            avs_waitrequest_out <= 1'b1;
            ram_en_out          <= FCR_RST_RAM_CTRL[FCR_BIT_RAM_EN];
            ram_mode_out        <= FCR_RST_RAM_CTRL[FCR_BIT_RAM_MODE];
            cmd_go_out          <= 1'b0;
            eff_start_out       <= 32'h00000000;
            eff_end_out         <= 32'h00000000;
            cmd_lock_out        <= 1'b0;
        end
        else if (ce_in)
        begin
            start_addr          <= next_start_addr;
            end_addr            <= next_end_addr;
            ready               <= next_ready;
            bc_dir              <= next_bc_dir;
            wait_q              <= next_wait;
            avs_readdata_out    <= next_readdata;
            avs_waitrequest_out <= next_wait;
            ram_en_out          <= next_ram_en;
            ram_mode_out        <= next_ram_mode;
            cmd_go_out          <= next_go;
            eff_start_out       <= next_eff_start;
            eff_end_out         <= next_eff_end;
            cmd_lock_out        <= next_lock;
        end
    end

    fcr_ram_gate u_gate (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .ce_in       (ce_in),
        .ram_en_in   (ram_en_out),
        .ram_mode_in (ram_mode_out),
        .rd_req_in   (fw_rd_in),
        .wr_req_in   (fw_wr_in),
        .hs_req_in   (fw_hs_in),
        .rd_ok_out   (fw_rd_ok_out),
        .wr_ok_out   (fw_wr_ok_out),
        .deny_out    (fw_deny_out)
    );

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_start_write_gated: assert property ( // R01
        (ce_in && acc_wr && hit_start && !ready && !do_init) |=> $stable(start_addr))
        else $error("start address changed while not ready");
    a_end_write_gated: assert property ( // R01
        (ce_in && acc_wr && hit_end && !ready && !do_init) |=> $stable(end_addr))
        else $error("end address changed while not ready");
    a_low_bits_fixed: assert property ( // R02
        start_addr[1:0] == 2'h0 && end_addr[1:0] == 2'h0)
        else $error("read-only address bits changed");
    a_init_clears_addr: assert property ( // R06
        (ce_in && do_init) |=> (start_addr == FCR_RST_ADDR) && (end_addr == FCR_RST_ADDR))
        else $error("init did not clear address registers");
    a_code_high_masked: assert property ( // R04
        (ce_in && cmd_issue_in && cmd_kind_in == FCR_CMD_CF_PROG) |=> eff_start_out[31:24] == 8'h00
            && eff_start_out[7:0] == 8'h00)
        else $error("code program address not masked");
    a_data_high_masked: assert property ( // R05
        (ce_in && cmd_issue_in && cmd_kind_in == FCR_CMD_DF_ERASE) |=> eff_start_out[31:19] == 13'h0000
            && eff_start_out[5:0] == 6'h00)
        else $error("data erase address not masked");
    a_blank_order_lock: assert property ( // R11
        (ce_in && cmd_issue_in && cmd_kind_in == FCR_CMD_BLANK && !bc_dir
            && (start_addr[18:2] >= end_addr[18:2])) |=> cmd_lock_out && !cmd_go_out)
        else $error("bad blank check order did not lock");
    a_decr_order_lock: assert property ( // R11
        (ce_in && cmd_issue_in && cmd_kind_in == FCR_CMD_BLANK && bc_dir
            && (start_addr[18:2] <= end_addr[18:2])) |=> cmd_lock_out && !cmd_go_out)
        else $error("bad decrementing blank check order did not lock");
    a_end_masked: assert property ( // R08
        (ce_in && cmd_issue_in) |=> eff_end_out[31:19] == 13'h0000 && eff_end_out[1:0] == 2'h0)
        else $error("end address not masked");
    a_key_guard: assert property ( // R12
        (ce_in && !(acc_wr && hit_ctrl && key_ok)) |=> $stable({ram_mode_out, ram_en_out}))
        else $error("ram control changed without key");
    a_ctrl_reads_low: assert property ( // R13
        (ce_in && avs_read_in && wait_q && hit_ctrl) |=> avs_readdata_out[31:2] == 30'h00000000)
        else $error("ram control upper bits not zero");
    a_ram_blocked: assert property ( // R14
        (ce_in && !ram_en_out) |=> !fw_rd_ok_out && !fw_wr_ok_out)
        else $error("firmware ram access while disabled");
    a_hs_mode_only: assert property ( // R15
        (ce_in && ram_mode_out && !fw_hs_in) |=> !fw_wr_ok_out && !fw_rd_ok_out)
        else $error("non high-speed access in high-speed mode");
    a_ready_follows: assert property ( // R18
        ce_in |=> ready == !$past(seq_busy_in))
        else $error("ready flag does not follow busy");
endmodule // fcr_regs

// *** sim/fcr_regs_tb.sv ***
// self-checking testbench for the flash command address register bank
`timescale 1ns/1ps
module fcr_regs_tb;
    import fcr_pkg::*;
    logic        mclk_in;
    logic        rstn_in;
    logic        ce_in;
    logic [31:0] avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        seq_busy_in;
    logic        cmd_issue_in;
    fcr_cmd_t    cmd_kind_in;
    logic        cmd_big_block_in;
    logic        lock_clear_in;
    logic        cmd_go_out;
    logic [31:0] eff_start_out;
    logic [31:0] eff_end_out;
    logic        cmd_lock_out;
    logic        ram_en_out;
    logic        ram_mode_out;
    logic        fw_rd_in;
    logic        fw_wr_in;
    logic        fw_hs_in;
    logic        fw_rd_ok_out;
    logic        fw_wr_ok_out;
    logic        fw_deny_out;
    int          num_errors;
    int          compares;
    int          cycles;
    logic [31:0] rd;

    fcr_regs dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .seq_busy_in(seq_busy_in), .cmd_issue_in(cmd_issue_in),
        .cmd_kind_in(cmd_kind_in), .cmd_big_block_in(cmd_big_block_in), .lock_clear_in(lock_clear_in),
        .cmd_go_out(cmd_go_out), .eff_start_out(eff_start_out), .eff_end_out(eff_end_out),
        .cmd_lock_out(cmd_lock_out), .ram_en_out(ram_en_out), .ram_mode_out(ram_mode_out),
        .fw_rd_in(fw_rd_in), .fw_wr_in(fw_wr_in), .fw_hs_in(fw_hs_in), .fw_rd_ok_out(fw_rd_ok_out),
        .fw_wr_ok_out(fw_wr_ok_out), .fw_deny_out(fw_deny_out));

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge mclk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors = num_errors + 1;
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                       input logic [3:0] be);
        @(posedge mclk_in);
        avs_address_in <= addr;
        avs_writedata_in <= data;
        avs_byteenable_in <= be;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h00000000, 4'hf);
        check(name, exp, rd);
    endtask

    task automatic issue(input fcr_cmd_t kind, input logic big, input logic exp_go, input logic [31:0] exp_st);
        @(posedge mclk_in);
        cmd_issue_in <= 1'b1;
        cmd_kind_in <= kind;
        cmd_big_block_in <= big;
        @(posedge mclk_in);
        cmd_issue_in <= 1'b0;
        #1;
        check("cmd_go", {31'h0, exp_go}, {31'h0, cmd_go_out});
        check("cmd_lock", {31'h0, ~exp_go}, {31'h0, cmd_lock_out});
        if (exp_go)
            check("eff_start", exp_st, eff_start_out);
    endtask

    task automatic fw(input logic r, input logic w, input logic hs, input logic [2:0] exp);
        @(posedge mclk_in);
        fw_rd_in <= r;
        fw_wr_in <= w;
        fw_hs_in <= hs;
        @(posedge mclk_in);
        fw_rd_in <= 1'b0;
        fw_wr_in <= 1'b0;
        fw_hs_in <= 1'b0;
        #1;
        check("fw_rd_wr_deny", {29'h0, exp}, {29'h0, fw_rd_ok_out, fw_wr_ok_out, fw_deny_out});
    endtask

    task automatic test_reset_values();
        rd_chk("start_rst", FCR_OFS_START_ADDR, FCR_RST_ADDR);
        rd_chk("end_rst", FCR_OFS_END_ADDR, FCR_RST_ADDR);
        rd_chk("ramctl_rst", FCR_OFS_RAM_CTRL, 32'h00000000);
        rd_chk("ready_idle", FCR_OFS_STATUS, 32'h00008000);
        rd_chk("unmapped", 32'h007fe0f0, 32'h00000000);
    endtask

    task automatic test_addr_regs();
        bus(1'b1, FCR_OFS_START_ADDR, 32'hffffffff, 4'hf);
        bus(1'b1, FCR_OFS_END_ADDR, 32'h12345677, 4'hf);
        rd_chk("start_ro_low", FCR_OFS_START_ADDR, 32'hfffffffc);
        rd_chk("end_ro_low", FCR_OFS_END_ADDR, 32'h12345674);
        @(posedge mclk_in);
        seq_busy_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rd_chk("ready_busy", FCR_OFS_STATUS, 32'h00000000);
        bus(1'b1, FCR_OFS_START_ADDR, 32'h00000100, 4'hf);
        bus(1'b1, FCR_OFS_END_ADDR, 32'h00000200, 4'hf);
        rd_chk("start_busy", FCR_OFS_START_ADDR, 32'hfffffffc);
        rd_chk("end_busy", FCR_OFS_END_ADDR, 32'h12345674);
        seq_busy_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        bus(1'b1, FCR_OFS_INIT, 32'h00000001, 4'hf);
        rd_chk("start_init", FCR_OFS_START_ADDR, FCR_RST_ADDR);
        rd_chk("end_init", FCR_OFS_END_ADDR, FCR_RST_ADDR);
    endtask

    task automatic test_ram_ctrl();
        fw(1'b1, 1'b0, 1'b0, 3'b001);
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h0000c5ff, 4'h3);
        rd_chk("ramctl_badkey", FCR_OFS_RAM_CTRL, 32'h00000000);
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h0000c401, 4'h1);
        rd_chk("ramctl_one_lane", FCR_OFS_RAM_CTRL, 32'h00000000);
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h0000c4fd, 4'h3);
        rd_chk("ramctl_key", FCR_OFS_RAM_CTRL, 32'h00000001);
        check("ram_en", 32'h1, {31'h0, ram_en_out});
        fw(1'b1, 1'b0, 1'b0, 3'b100);
        fw(1'b0, 1'b1, 1'b0, 3'b010);
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h0000c403, 4'h3);
        @(negedge mclk_in);
        check("ram_mode", 32'h1, {31'h0, ram_mode_out});
        fw(1'b1, 1'b0, 1'b0, 3'b001);
        fw(1'b0, 1'b1, 1'b1, 3'b010);
        fw(1'b0, 1'b1, 1'b0, 3'b001);
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h00000000, 4'h3);
        @(negedge mclk_in);
        check("ram_en_kept", 32'h1, {31'h0, ram_en_out});
        bus(1'b1, FCR_OFS_RAM_CTRL, 32'h0000c400, 4'h3);
        fw(1'b1, 1'b0, 1'b0, 3'b001);
    endtask

    task automatic clear_lock();
        @(posedge mclk_in);
        lock_clear_in <= 1'b1;
        @(posedge mclk_in);
        lock_clear_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic test_commands();
        bus(1'b1, FCR_OFS_START_ADDR, 32'hffffffff, 4'hf);
        issue(FCR_CMD_CF_PROG, 1'b0, 1'b1, 32'h00ffff00);
        issue(FCR_CMD_DF_PROG, 1'b0, 1'b1, 32'h0007fffc);
        issue(FCR_CMD_CF_ERASE, 1'b0, 1'b1, 32'h00ffe000);
        issue(FCR_CMD_CF_ERASE, 1'b1, 1'b1, 32'h00ff8000);
        issue(FCR_CMD_DF_ERASE, 1'b0, 1'b1, 32'h0007ffc0);
        issue(FCR_CMD_CONFIG, 1'b0, 1'b1, 32'h0007fff0);
        issue(FCR_CMD_LOCK_PROG, 1'b1, 1'b1, 32'h00ff8000);
        issue(FCR_CMD_LOCK_READ, 1'b0, 1'b1, 32'h00ffe000);
        bus(1'b1, FCR_OFS_START_ADDR, 32'hfff00101, 4'hf);
        bus(1'b1, FCR_OFS_END_ADDR, 32'hfff00207, 4'hf);
        bus(1'b1, FCR_OFS_BC_CTRL, 32'h00000000, 4'hf);
        issue(FCR_CMD_BLANK, 1'b0, 1'b1, 32'h00000100);
        check("eff_end", 32'h00000204, eff_end_out);
        bus(1'b1, FCR_OFS_BC_CTRL, 32'h00000001, 4'hf);
        issue(FCR_CMD_BLANK, 1'b0, 1'b0, 32'h00000000);
        clear_lock();
        bus(1'b1, FCR_OFS_END_ADDR, 32'h00000100, 4'hf);
        issue(FCR_CMD_BLANK, 1'b0, 1'b0, 32'h00000000);
        clear_lock();
        bus(1'b1, FCR_OFS_END_ADDR, 32'h000000fc, 4'hf);
        issue(FCR_CMD_BLANK, 1'b0, 1'b1, 32'h00000100);
        bus(1'b1, FCR_OFS_BC_CTRL, 32'h00000000, 4'hf);
        issue(FCR_CMD_BLANK, 1'b0, 1'b0, 32'h00000000);
        clear_lock();
    endtask

    // clock enable low: an issued command must leave cmd_go_out and eff_start_out frozen
    task automatic test_freeze();
        @(posedge mclk_in);
        ce_in <= 1'b0;
        cmd_issue_in <= 1'b1;
        cmd_kind_in <= FCR_CMD_CF_PROG;
        @(posedge mclk_in);
        cmd_issue_in <= 1'b0;
        #1;
        check("go_frozen", 32'h00000000, {31'h0, cmd_go_out});
        check("eff_frozen", 32'h00000100, eff_start_out);
        @(posedge mclk_in);
        ce_in <= 1'b1;
        @(posedge mclk_in);
    endtask

    initial
    begin
        num_errors = 0;
        compares = 0;
        cycles <= 0;
        rstn_in <= 1'b0;
        ce_in <= 1'b1;
        avs_address_in <= 32'h00000000;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        avs_writedata_in <= 32'h00000000;
        avs_byteenable_in <= 4'h0;
        seq_busy_in <= 1'b0;
        cmd_issue_in <= 1'b0;
        cmd_kind_in <= FCR_CMD_CF_PROG;
        cmd_big_block_in <= 1'b0;
        lock_clear_in <= 1'b0;
        fw_rd_in <= 1'b0;
        fw_wr_in <= 1'b0;
        fw_hs_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        test_reset_values();
        test_addr_regs();
        test_ram_ctrl();
        test_commands();
        test_freeze();
        complete_run();
    end
endmodule // fcr_regs_tb
